/* src/lsr_cfg.svh */
// Constants of the laser safety restart controller: timing, modes, registers.
// Assumes a 10 MHz system clock and one 1 ms tick as the slow timebase.
`ifndef LSR_CFG_SVH
`define LSR_CFG_SVH
// ----------------------------------------------------------------------------
// Timebase.
// ----------------------------------------------------------------------------
`define LSR_CLK_HZ 10000000
`define LSR_TICK_MS 1
`define LSR_TICK_CYC ((`LSR_CLK_HZ / 1000) * `LSR_TICK_MS)
`define LSR_SC_PULSE_MS 2000
`define LSR_AMP_PULSE_MS 9000
`define LSR_WAIT_MS 100000
`define LSR_SHUT_MAX_MS 3000
// ----------------------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------------------
`define LSR_A_CTRL 12'h000
`define LSR_A_CMD 12'h004
`define LSR_A_STAT 12'h008
`define LSR_A_IRQ_ST 12'h00c
`define LSR_A_IRQ_EN 12'h010
`define LSR_A_IRQ_CLR 12'h014
// ----------------------------------------------------------------------------
// Fields.
// ----------------------------------------------------------------------------
`define LSR_MODE_DIS 2'h0
`define LSR_MODE_AUTO 2'h1
`define LSR_MODE_MAN 2'h2
`define LSR_MODE_TEST 2'h3
`define LSR_CMD_RESTART 0
`define LSR_IRQ_SHUT 0
`define LSR_IRQ_CONTACT 1
`define LSR_IRQ_NORMAL 2
`define LSR_IRQ_RETRY 3
`define LSR_IRQ_W 4
`endif

/* src/lsr_pkg.sv */
// Types shared by the laser safety restart controller files.
// Assumes lsr_cfg.svh for the numeric constants.
`default_nettype none
package lsr_pkg;
   // Controller states of the shutdown and restart sequence.
   typedef enum logic [2:0] {
      LSR_NORMAL,
      LSR_SHUT,
      LSR_HOLD,
      LSR_SC_PULSE,
      LSR_SC_WAIT,
      LSR_AMP_PULSE,
      LSR_AMP_WAIT
   } lsr_state_t;
endpackage
`default_nettype wire

/* src/lsr_timer.sv */
// Millisecond timer used by the restart controller.
// Assumes a one-cycle tick enable from the parent's divider.
`timescale 1ns/1ps
`default_nettype none
module lsr_timer #(
   parameter int W = 17
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic clear_in,
   input wire logic tick_in,
   output logic [W-1:0] ms_out
);
   // ----------------------------------------------------------------------------
   // Counter.
   // ----------------------------------------------------------------------------
   // Clear wins over a tick so each state starts counting from zero.
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ms_out <= '0;
      end else if (clear_in) begin
         ms_out <= '0;
      end else if (tick_in && ms_out != {W{1'b1}}) begin
         ms_out <= ms_out + 1'b1;
      end
   end
endmodule
`default_nettype wire

/* src/lsr_ctrl.sv */
// Laser safety shutdown and restart controller with an APB register slave.
// Assumes synchronous loss indications and a peer that answers restart pulses.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "lsr_cfg.svh"
module lsr_ctrl #(
   parameter bit PORT_VARIANT = 1'b0,
   parameter int TICK_CYC = `LSR_TICK_CYC,
   parameter int SC_PULSE_MS = `LSR_SC_PULSE_MS,
   parameter int AMP_PULSE_MS = `LSR_AMP_PULSE_MS,
   parameter int WAIT_MS = `LSR_WAIT_MS
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic overhead_light_loss_in,
   input wire logic payload_light_loss_in,
   output logic service_channel_tx_en_out,
   output logic service_channel_low_power_out,
   output logic amp_en_out,
   output logic restart_power_reduction_out,
   output logic irq_out
);
   // ----------------------------------------------------------------------------
   // Declarations.
   // ----------------------------------------------------------------------------
   localparam int TW = 17; // Wide enough for the 100 s wait in ms.
   logic [1:0] mode_r; // Provisioned mode.
   logic restart_cmd; // One-cycle restart command from software.
   lsr_pkg::lsr_state_t state_r, state_nxt; // Sequencer state.
   logic [$clog2(TICK_CYC+1)-1:0] div_r; // Timebase divider.
   logic tick_r; // One-cycle 1 ms enable.
   logic [TW-1:0] ms; // Time in current state.
   logic state_chg; // Restarts the timer.
   logic loss; // Combined loss of light.
   logic [TW-1:0] ans_ms_r; // Width of the peer's current answer pulse.
   logic ans_prev_r; // Last sampled answer level.
   logic answer_done; // Answer of enough width just ended.
   logic [TW-1:0] need_ms; // Answer width required in this state.
   logic [`LSR_IRQ_W-1:0] irq_st_r, irq_en_r, irq_set; // Interrupt registers.
   logic apb_wr, apb_rd; // Access-phase strobes.

   assign loss = overhead_light_loss_in & payload_light_loss_in;
   assign apb_wr = psel_in & penable_in & pwrite_in;
   assign apb_rd = psel_in & penable_in & ~pwrite_in;
   assign restart_cmd = apb_wr && paddr_in == `LSR_A_CMD && pwdata_in[`LSR_CMD_RESTART];

   // ----------------------------------------------------------------------------
   // Timebase.
   // ----------------------------------------------------------------------------
   // A divider makes the 1 ms enable; all protocol times count in ms.
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         div_r <= '0;
         tick_r <= 1'b0;
      end else if (div_r == ($clog2(TICK_CYC+1))'(TICK_CYC - 1)) begin
         div_r <= '0;
         tick_r <= 1'b1;
      end else begin
         div_r <= div_r + 1'b1;
         tick_r <= 1'b0;
      end
   end

   lsr_timer #(.W(TW)) u_timer (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .clear_in(state_chg),
      .tick_in(tick_r),
      .ms_out(ms)
   );

   // ----------------------------------------------------------------------------
   // Peer answer pulse measurement.
   // ----------------------------------------------------------------------------
   // The peer's answer shows as light returning on either path; we measure how
   // long it stays and accept it on its falling edge if wide enough.
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ans_ms_r <= '0;
         ans_prev_r <= 1'b0;
      end else begin
         ans_prev_r <= ~loss;
         if (loss) begin
            ans_ms_r <= '0;
         end else if (tick_r && ans_ms_r != {TW{1'b1}}) begin
            ans_ms_r <= ans_ms_r + 1'b1;
         end
      end
   end
   assign need_ms = (state_r == lsr_pkg::LSR_AMP_WAIT) ? TW'(AMP_PULSE_MS) : TW'(SC_PULSE_MS);
   assign answer_done = ans_prev_r & loss & (ans_ms_r >= need_ms);

   // ----------------------------------------------------------------------------
   // Sequencer.
   // ----------------------------------------------------------------------------
   // Next-state logic for shutdown, handshake and recovery.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         lsr_pkg::LSR_NORMAL: begin
            if (mode_r == `LSR_MODE_TEST && restart_cmd) begin
               state_nxt = lsr_pkg::LSR_SC_PULSE;
            end else if (mode_r != `LSR_MODE_DIS && loss) begin
               state_nxt = lsr_pkg::LSR_SHUT;
            end
         end
         lsr_pkg::LSR_SHUT: begin
            // Outputs are already off; decide how the restart begins.
            if (mode_r == `LSR_MODE_DIS) begin
               state_nxt = lsr_pkg::LSR_NORMAL;
            end else if (mode_r == `LSR_MODE_AUTO) begin
               state_nxt = lsr_pkg::LSR_SC_PULSE;
            end else begin
               state_nxt = lsr_pkg::LSR_HOLD;
            end
         end
         lsr_pkg::LSR_HOLD: begin
            if (restart_cmd) begin
               state_nxt = lsr_pkg::LSR_SC_PULSE;
            end else if (mode_r == `LSR_MODE_AUTO) begin
               state_nxt = lsr_pkg::LSR_SC_PULSE;
            end else if (mode_r == `LSR_MODE_DIS) begin
               state_nxt = lsr_pkg::LSR_NORMAL;
            end
         end
         lsr_pkg::LSR_SC_PULSE: begin
            if (ms >= TW'(SC_PULSE_MS)) begin
               state_nxt = lsr_pkg::LSR_SC_WAIT;
            end
         end
         lsr_pkg::LSR_SC_WAIT: begin
            if (answer_done) begin
               state_nxt = PORT_VARIANT ? lsr_pkg::LSR_NORMAL : lsr_pkg::LSR_AMP_PULSE;
            end else if (ms >= TW'(WAIT_MS)) begin
               state_nxt = lsr_pkg::LSR_SC_PULSE;
            end
         end
         lsr_pkg::LSR_AMP_PULSE: begin
            if (ms >= TW'(AMP_PULSE_MS)) begin
               state_nxt = lsr_pkg::LSR_AMP_WAIT;
            end
         end
         lsr_pkg::LSR_AMP_WAIT: begin
            if (answer_done) begin
               state_nxt = lsr_pkg::LSR_NORMAL;
            end else if (ms >= TW'(WAIT_MS)) begin
               state_nxt = lsr_pkg::LSR_SC_PULSE;
            end
         end
         default: begin
            state_nxt = lsr_pkg::LSR_SHUT;
         end
      endcase
   end
   assign state_chg = state_nxt != state_r;

   // State register.
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_r <= lsr_pkg::LSR_NORMAL;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ----------------------------------------------------------------------------
   // Optical outputs.
   // ----------------------------------------------------------------------------
   // Registered from the next state, so shutdown reaches the pins one cycle
   // after loss, far inside the three-second bound. Reduction is not a
   // register field: software cannot bypass it.
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         service_channel_tx_en_out <= 1'b1;
         service_channel_low_power_out <= 1'b0;
         amp_en_out <= 1'b1;
         restart_power_reduction_out <= 1'b0;
      end else begin
         service_channel_tx_en_out <= state_nxt == lsr_pkg::LSR_NORMAL || state_nxt == lsr_pkg::LSR_SC_PULSE
            || state_nxt == lsr_pkg::LSR_AMP_PULSE || state_nxt == lsr_pkg::LSR_AMP_WAIT;
         service_channel_low_power_out <= state_nxt == lsr_pkg::LSR_SC_PULSE;
         amp_en_out <= state_nxt == lsr_pkg::LSR_NORMAL || state_nxt == lsr_pkg::LSR_AMP_PULSE;
         restart_power_reduction_out <= state_nxt == lsr_pkg::LSR_AMP_PULSE;
      end
   end

   // ----------------------------------------------------------------------------
   // Registers.
   // ----------------------------------------------------------------------------
   // Mode register; the port variant comes out of reset disabled.
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         mode_r <= PORT_VARIANT ? `LSR_MODE_DIS : `LSR_MODE_AUTO;
      end else if (apb_wr && paddr_in == `LSR_A_CTRL) begin
         mode_r <= pwdata_in[1:0];
      end
   end

   // Interrupt events: shutdown, contact, normal power, retry.
   assign irq_set[`LSR_IRQ_SHUT] = state_chg && state_nxt == lsr_pkg::LSR_SHUT;
   assign irq_set[`LSR_IRQ_CONTACT] = state_r == lsr_pkg::LSR_SC_WAIT && answer_done;
   assign irq_set[`LSR_IRQ_NORMAL] = state_r == lsr_pkg::LSR_AMP_WAIT && answer_done;
   assign irq_set[`LSR_IRQ_RETRY] = state_chg && state_nxt == lsr_pkg::LSR_SC_PULSE
      && (state_r == lsr_pkg::LSR_SC_WAIT || state_r == lsr_pkg::LSR_AMP_WAIT);

   // Sticky status: a set in the clearing cycle wins.
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_st_r <= '0;
      end else begin
         irq_st_r <= (irq_st_r & ~((apb_wr && paddr_in == `LSR_A_IRQ_CLR) ? pwdata_in[`LSR_IRQ_W-1:0]
            : {`LSR_IRQ_W{1'b0}})) | irq_set;
      end
   end

   // Interrupt enable register.
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_en_r <= '0;
      end else if (apb_wr && paddr_in == `LSR_A_IRQ_EN) begin
         irq_en_r <= pwdata_in[`LSR_IRQ_W-1:0];
      end
   end

   // Interrupt line, from a flip-flop.
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(irq_st_r & irq_en_r);
      end
   end

   // APB slave: every access ends in its first access cycle (pready high).
   // Unmapped addresses answer with pslverr; reads of write-only words give 0.
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         prdata_out <= '0;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end else begin
         pready_out <= psel_in & ~penable_in;
         pslverr_out <= 1'b0;
         prdata_out <= '0;
         if (psel_in && !penable_in) begin
            case (paddr_in)
               `LSR_A_CTRL: prdata_out <= {30'h0, mode_r};
               `LSR_A_CMD: prdata_out <= '0;
               `LSR_A_STAT: prdata_out <= {29'h0, state_r};
               `LSR_A_IRQ_ST: prdata_out <= {28'h0, irq_st_r};
               `LSR_A_IRQ_EN: prdata_out <= {28'h0, irq_en_r};
               `LSR_A_IRQ_CLR: prdata_out <= '0;
               default: pslverr_out <= 1'b1;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------------------------
   property p_dis_no_shut;
      @(posedge sys_clk_in) disable iff (rst_in)
      (mode_r == `LSR_MODE_DIS && state_r == lsr_pkg::LSR_NORMAL && !restart_cmd) |=> state_r == lsr_pkg::LSR_NORMAL;
   endproperty
   a_dis_no_shut: assert property (p_dis_no_shut) else $error("Disabled mode left normal state.");

   property p_shut;
      @(posedge sys_clk_in) disable iff (rst_in)
      (mode_r != `LSR_MODE_DIS && mode_r != `LSR_MODE_TEST && state_r == lsr_pkg::LSR_NORMAL && loss)
      |=> ##1 !amp_en_out;
   endproperty
   a_shut: assert property (p_shut) else $error("Amplifier not shut after loss.");

   property p_manual_hold;
      @(posedge sys_clk_in) disable iff (rst_in)
      (state_r == lsr_pkg::LSR_HOLD && mode_r == `LSR_MODE_MAN && !restart_cmd) |=> state_r == lsr_pkg::LSR_HOLD;
   endproperty
   a_manual_hold: assert property (p_manual_hold) else $error("Manual hold left without command.");

   property p_auto_restart;
      @(posedge sys_clk_in) disable iff (rst_in)
      (state_r == lsr_pkg::LSR_SHUT && mode_r == `LSR_MODE_AUTO) |=> state_r == lsr_pkg::LSR_SC_PULSE;
   endproperty
   a_auto_restart: assert property (p_auto_restart) else $error("Auto mode did not start handshake.");

   property p_reduce;
      @(posedge sys_clk_in) disable iff (rst_in)
      amp_en_out && state_r == lsr_pkg::LSR_AMP_PULSE |-> restart_power_reduction_out;
   endproperty
   a_reduce: assert property (p_reduce) else $error("Amplifier pulse without reduction.");

   property p_sc_pulse_end;
      @(posedge sys_clk_in) disable iff (rst_in)
      (state_r == lsr_pkg::LSR_SC_PULSE && ms >= TW'(SC_PULSE_MS)) |=> state_r == lsr_pkg::LSR_SC_WAIT;
   endproperty
   a_sc_pulse_end: assert property (p_sc_pulse_end) else $error("Service pulse overran.");

   property p_retry;
      @(posedge sys_clk_in) disable iff (rst_in)
      (state_r == lsr_pkg::LSR_SC_WAIT && ms >= TW'(WAIT_MS) && !answer_done) |=> state_r == lsr_pkg::LSR_SC_PULSE;
   endproperty
   a_retry: assert property (p_retry) else $error("No retry after wait window.");

   property p_amp_timeout;
      @(posedge sys_clk_in) disable iff (rst_in)
      (state_r == lsr_pkg::LSR_AMP_WAIT && ms >= TW'(WAIT_MS) && !answer_done) |=> state_r == lsr_pkg::LSR_SC_PULSE;
   endproperty
   a_amp_timeout: assert property (p_amp_timeout) else $error("No handshake restart after wait.");

   property p_normal;
      @(posedge sys_clk_in) disable iff (rst_in)
      (state_r == lsr_pkg::LSR_AMP_WAIT && answer_done) |=> ##1 (amp_en_out && !restart_power_reduction_out);
   endproperty
   a_normal: assert property (p_normal) else $error("Normal power not restored.");

   c_shut: cover property (@(posedge sys_clk_in) state_r == lsr_pkg::LSR_SHUT);
   c_contact: cover property (@(posedge sys_clk_in) state_r == lsr_pkg::LSR_AMP_PULSE);
   c_back: cover property (@(posedge sys_clk_in) state_r == lsr_pkg::LSR_AMP_WAIT ##1 state_r == lsr_pkg::LSR_NORMAL);
endmodule
`default_nettype wire

/* verif/lsr_peer_model.sv */
// Far-end node model: answers restart pulses by lighting the fibre.
// Assumes the near end's laser outputs are levels on the same clock.
`timescale 1ns/1ps
`default_nettype none
module lsr_peer_model #(
   parameter int TICK_CYC = 10,
   parameter int SC_MS = 4,
   parameter int AMP_MS = 8
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic cut_in,
   input wire logic oh_only_in,
   input wire logic ans_sc_in,
   input wire logic ans_amp_in,
   input wire logic [7:0] delay_in,
   input wire logic near_tx_in,
   input wire logic near_lp_in,
   input wire logic near_amp_in,
   input wire logic near_red_in,
   output logic overhead_light_loss_out,
   output logic payload_light_loss_out
);
   logic lit_r; // Far end runs normally with its lasers on.
   logic lp_d_r; // Last near-end low-power level, for the falling edge.
   logic red_d_r; // Last near-end reduced-power level.
   logic amp_ans_r; // The answer under way is the amplifier stage.
   int cnt_r; // Countdown: delay, light window, then one dark cycle.
   int win_r; // Light window of the answer under way.
   logic light;
   // The far end answers only after the near pulse ends, after a delay.
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         lit_r <= 1'b1;
         lp_d_r <= 1'b0;
         red_d_r <= 1'b0;
         amp_ans_r <= 1'b0;
         cnt_r <= 0;
         win_r <= 0;
      end else begin
         lp_d_r <= near_lp_in;
         red_d_r <= near_red_in;
         // Losing all near light shuts the far end down too.
         if (!near_tx_in && !near_amp_in && cnt_r == 0) begin
            lit_r <= 1'b0;
         end
         if (cnt_r > 0) begin
            cnt_r <= cnt_r - 1;
            if (cnt_r == 1 && amp_ans_r) begin
               lit_r <= 1'b1;
            end
         end else if (lp_d_r && !near_lp_in && ans_sc_in) begin
            win_r <= (SC_MS + 1) * TICK_CYC;
            cnt_r <= int'(delay_in) + (SC_MS + 1) * TICK_CYC + 1;
            amp_ans_r <= 1'b0;
         end else if (red_d_r && !near_red_in && ans_amp_in) begin
            win_r <= (AMP_MS + 1) * TICK_CYC;
            cnt_r <= int'(delay_in) + (AMP_MS + 1) * TICK_CYC + 1;
            amp_ans_r <= 1'b1;
         end
      end
   end
   // A dark fibre shows loss on both monitors; a cut hides everything.
   assign light = !cut_in && (lit_r || (cnt_r > 1 && cnt_r <= win_r + 1));
   assign payload_light_loss_out = !light;
   assign overhead_light_loss_out = !light || oh_only_in;
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench of the laser safety restart controller.
// Assumes lsr_cfg.svh and lsr_pkg; a second instance is the port variant.
`timescale 1ns/1ps
`default_nettype none
`include "lsr_cfg.svh"
module tb_top;
   localparam int TK = 10;
   localparam int WT = 40;
   typedef struct {bit ck; logic [32:0] e;} lsr_note_t;
   logic clk, rst, psel, psel_p, pen, pwr, oh, pl, rdy_d, rdy_p, err_d, err_p;
   logic [11:0] pa;
   logic [31:0] pwd, rd_d, rd_p, rd, r;
   logic tx, lp, amp, red, irq, tx_p, cut, oho, asc, aamp;
   logic [7:0] dly;
   int failures, tests_run, cyc, t0;
   lsr_note_t notes[$];
   lsr_note_t nt;
   lsr_ctrl #(.TICK_CYC(TK), .SC_PULSE_MS(4), .AMP_PULSE_MS(8), .WAIT_MS(WT)) u_dut (.sys_clk_in(clk),
      .rst_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
      .prdata_out(rd_d), .pready_out(rdy_d), .pslverr_out(err_d), .overhead_light_loss_in(oh),
      .payload_light_loss_in(pl), .service_channel_tx_en_out(tx), .service_channel_low_power_out(lp),
      .amp_en_out(amp), .restart_power_reduction_out(red), .irq_out(irq));
   lsr_ctrl #(.PORT_VARIANT(1'b1), .TICK_CYC(TK), .WAIT_MS(WT)) u_port (.sys_clk_in(clk), .rst_in(rst),
      .psel_in(psel_p), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
      .prdata_out(rd_p), .pready_out(rdy_p), .pslverr_out(err_p), .overhead_light_loss_in(oh),
      .payload_light_loss_in(pl), .service_channel_tx_en_out(tx_p), .service_channel_low_power_out(),
      .amp_en_out(), .restart_power_reduction_out(), .irq_out());
   lsr_peer_model #(.TICK_CYC(TK), .SC_MS(4), .AMP_MS(8)) u_peer (.sys_clk_in(clk), .rst_in(rst),
      .cut_in(cut), .oh_only_in(oho), .ans_sc_in(asc), .ans_amp_in(aamp), .delay_in(dly),
      .near_tx_in(tx), .near_lp_in(lp), .near_amp_in(amp), .near_red_in(red),
      .overhead_light_loss_out(oh), .payload_light_loss_out(pl));
   // ---------------------------------------------------------------------
   // Clock, cycle count, watchdog and read checker.
   // ---------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   // The tests take about 3000 cycles; a hang is cut well beyond that.
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      complete_run();
   end
   // Each finished read takes the oldest note; a note that expects an error compares only the error flag.
   always @(posedge clk) begin
      if (pen && !pwr && ((psel && rdy_d) || (psel_p && rdy_p)) && notes.size() > 0) begin
         nt = notes.pop_front();
         if (nt.ck) begin
            chk("apb_read", (psel ? {err_d, rd_d} : {err_p, rd_p}) & (nt.e[32] ? 33'h100000000 : '1), nt.e);
         end
      end
   end
   task automatic chk(input string n, input logic [32:0] s, input logic [32:0] e);
      tests_run++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   // One APB transfer; the request is held until pready is seen high.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input bit ck = 0,
                      input logic [32:0] e = '0, input bit pt = 0);
      @(posedge clk);
      psel <= !pt;
      psel_p <= pt;
      pen <= 1'b0;
      pwr <= w;
      pa <= a;
      pwd <= d;
      if (!w) notes.push_back('{ck, e});
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (!(pt ? rdy_p : rdy_d));
      rd = pt ? rd_p : rd_d;
      psel <= 1'b0;
      psel_p <= 1'b0;
      pen <= 1'b0;
   endtask
   // Polls the state register, bounded, then checks the state reached.
   task automatic wait_st(input lsr_pkg::lsr_state_t s, input bit pt = 0);
      for (int i = 0; i < 400; i++) begin
         apb(1'b0, `LSR_A_STAT, 32'h0, 0, '0, pt);
         if (rd[2:0] === s) break;
      end
      chk("state", {30'h0, rd[2:0]}, {30'h0, s});
   endtask
   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ---------------------------------------------------------------------
   // Main sequence.
   // ---------------------------------------------------------------------
   initial begin
      failures = 0;
      tests_run = 0;
      cyc = 0;
      rst = 1'b1;
      {psel, psel_p, pen, pwr, cut, oho} = '0;
      {asc, aamp} = 2'b11;
      pa = '0;
      pwd = '0;
      dly = 8'h01;
      void'($urandom(2));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      apb(0, `LSR_A_CTRL, 0, 1, {31'h0, `LSR_MODE_AUTO});
      apb(0, `LSR_A_CTRL, 0, 1, {31'h0, `LSR_MODE_DIS}, 1);
      apb(0, 12'h018, 0, 1, {1'b1, 32'h0});
      apb(0, `LSR_A_CMD, 0, 1, 33'h0);
      r = $urandom & 32'hf;
      apb(1, `LSR_A_IRQ_EN, r);
      apb(0, `LSR_A_IRQ_EN, 0, 1, {1'b0, r});
      apb(1, `LSR_A_IRQ_EN, 32'hf);
      // Overhead loss alone must not shut anything down.
      oho <= 1'b1;
      repeat (60) @(posedge clk);
      apb(0, `LSR_A_STAT, 0, 1, {30'h0, lsr_pkg::LSR_NORMAL});
      oho <= 1'b0;
      apb(1, `LSR_A_CTRL, {30'h0, `LSR_MODE_DIS});
      cut <= 1'b1;
      repeat (60) @(posedge clk);
      chk("amp_en", amp, 1);
      chk("tx_en", tx, 1);
      cut <= 1'b0;
      // Auto restart with a silent far end first, then a slow answer.
      apb(1, `LSR_A_CTRL, {30'h0, `LSR_MODE_AUTO});
      asc <= 1'b0;
      dly <= 8'($urandom_range(1, 40));
      cut <= 1'b1;
      // Auto mode stays dark for one cycle only, then starts the restart pulse.
      repeat (2) @(posedge clk);
      chk("amp_en", amp, 0);
      chk("tx_en", tx, 0);
      cut <= 1'b0;
      wait_st(lsr_pkg::LSR_SC_PULSE);
      chk("low_power", lp, 1);
      wait_st(lsr_pkg::LSR_SC_WAIT);
      t0 = cyc;
      wait_st(lsr_pkg::LSR_SC_PULSE);
      chk("retry_gap", {32'h0, (cyc - t0 >= WT * TK - 15) && (cyc - t0 <= WT * TK + 20)}, 33'h1);
      asc <= 1'b1;
      aamp <= 1'b0;
      wait_st(lsr_pkg::LSR_AMP_PULSE);
      chk("reduction", red, 1);
      chk("amp_en", amp, 1);
      wait_st(lsr_pkg::LSR_SC_PULSE);
      chk("amp_en", amp, 0);
      aamp <= 1'b1;
      wait_st(lsr_pkg::LSR_NORMAL);
      chk("reduction", red, 0);
      chk("amp_en", amp, 1);
      chk("tx_en", tx, 1);
      apb(0, `LSR_A_IRQ_ST, 0, 1, 33'hf);
      chk("irq", irq, 1);
      apb(1, `LSR_A_IRQ_CLR, 32'hf);
      apb(0, `LSR_A_IRQ_ST, 0, 1, 33'h0);
      chk("irq", irq, 0);
      // Manual restart with the interrupt masked, then unmasked.
      apb(1, `LSR_A_IRQ_EN, 32'h0);
      apb(1, `LSR_A_CTRL, {30'h0, `LSR_MODE_MAN});
      cut <= 1'b1;
      repeat (4) @(posedge clk);
      cut <= 1'b0;
      wait_st(lsr_pkg::LSR_HOLD);
      repeat (600) @(posedge clk);
      apb(0, `LSR_A_STAT, 0, 1, {30'h0, lsr_pkg::LSR_HOLD});
      chk("tx_en", tx, 0);
      chk("irq", irq, 0);
      apb(0, `LSR_A_IRQ_ST, 0, 1, 33'h1);
      apb(1, `LSR_A_IRQ_EN, 32'h1);
      repeat (2) @(posedge clk);
      chk("irq", irq, 1);
      apb(1, `LSR_A_IRQ_CLR, 32'hf);
      apb(1, `LSR_A_CMD, 32'h1 << `LSR_CMD_RESTART);
      wait_st(lsr_pkg::LSR_NORMAL);
      // Test command from normal runs a full restart.
      apb(1, `LSR_A_CTRL, {30'h0, `LSR_MODE_TEST});
      apb(1, `LSR_A_CMD, 32'h1 << `LSR_CMD_RESTART);
      wait_st(lsr_pkg::LSR_SC_PULSE);
      wait_st(lsr_pkg::LSR_NORMAL);
      // The port variant stayed lit through every cut until enabled.
      chk("port_tx_en", tx_p, 1);
      apb(1, `LSR_A_CTRL, {30'h0, `LSR_MODE_AUTO}, 0, '0, 1);
      cut <= 1'b1;
      // The port variant goes dark for one cycle only before its own pulse.
      repeat (2) @(posedge clk);
      chk("port_tx_en", tx_p, 0);
      cut <= 1'b0;
      wait_st(lsr_pkg::LSR_SC_PULSE, 1);
      complete_run();
   end
endmodule
`default_nettype wire
